/* File: core/wsc_cfg.svh */
// wsc_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from design and verification files
`ifndef WSC_CFG_SVH
`define WSC_CFG_SVH
// register byte addresses on apb
`define WSC_OFS_CONTROL      12'h000
`define WSC_OFS_STEER        12'h004
`define WSC_OFS_POLARITY     12'h008
`define WSC_OFS_FIXED        12'h00C
`define WSC_OFS_STATUS       12'h010
// control field positions
`define WSC_CTL_EN_BIT       7
`define WSC_CTL_LD_BIT       6
`define WSC_CTL_MODE_HI      2
`define WSC_CTL_MODE_LO      0
// reset values
`define WSC_RST_CONTROL      8'h00
`define WSC_RST_STEER        4'h0
`define WSC_RST_POLARITY     4'h0
`define WSC_RST_FIXED        4'h0
// timing: clock period in ns, apb answer wait states
`define WSC_CLK_PERIOD_NS    100
`define WSC_APB_WAIT         0
`endif

/* File: core/wsc_pkg.sv */
// wsc_pkg.sv: types for the waveform steering control block
// assumes: constants live in wsc_cfg.svh
package wsc_pkg;
   typedef enum logic [2:0] {
      WSC_MODE_STEER      = 3'b000,
      WSC_MODE_SYNC_STEER = 3'b001,
      WSC_MODE_FWD_FULL   = 3'b010,
      WSC_MODE_REV_FULL   = 3'b011,
      WSC_MODE_HALF       = 3'b100,
      WSC_MODE_PUSH_PULL  = 3'b101,
      WSC_MODE_RSVD6      = 3'b110,
      WSC_MODE_RSVD7      = 3'b111
   } wsc_mode_e;
   typedef logic [3:0] wsc_pins_t;
endpackage : wsc_pkg

/* File: core/wsc_edge_detect.sv */
// wsc_edge_detect.sv: rising and falling edge pulses of the modulated data input
// assumes: data input is synchronous to the clock
`timescale 1ns/1ns
module wsc_edge_detect (
   input  wire logic core_clk_in,
   input  wire logic reset_n_in,
   input  wire logic data_in,
   output logic      rise_out,
   output logic      fall_out
);
   typedef struct packed {
      logic prev;
   } wsc_edge_state_s;
   wsc_edge_state_s st;
   wsc_edge_state_s next_st;
   // remember last sample
   always_comb begin
      next_st.prev = data_in;
   end
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   // combinational pulses; registered by the top before leaving
   assign rise_out = data_in & ~st.prev;
   assign fall_out = ~data_in & st.prev;
endmodule : wsc_edge_detect

/* File: core/wsc_mode_drive.sv */
// wsc_mode_drive.sv: raw pin levels for the bridge and push-pull modes
// assumes: steering modes are formed in the top; this covers codes 010..101
`timescale 1ns/1ns
module wsc_mode_drive (
   input  wire logic              core_clk_in,
   input  wire logic              reset_n_in,
   input  wire logic [2:0]        mode_in,
   input  wire logic              data_in,
   input  wire logic              rise_in,
   output wsc_pkg::wsc_pins_t     pins_out
);
   typedef struct packed {
      logic phase;
   } wsc_drive_state_s;
   wsc_drive_state_s st;
   wsc_drive_state_s next_st;
   // push-pull toggles phase on each rising data edge
   always_comb begin
      next_st = st;
      if (rise_in) begin
         next_st.phase = ~st.phase;
      end
   end
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   // no dead-band here; external drivers must tolerate direct complements
   always_comb begin
      pins_out = 4'h0;
      unique case (wsc_pkg::wsc_mode_e'(mode_in))
         wsc_pkg::WSC_MODE_FWD_FULL: begin
            pins_out = {data_in, 1'b0, 1'b0, 1'b1};
         end
         wsc_pkg::WSC_MODE_REV_FULL: begin
            pins_out = {1'b0, 1'b1, data_in, 1'b0};
         end
         wsc_pkg::WSC_MODE_HALF: begin
            pins_out = {~data_in, data_in, ~data_in, data_in};
         end
         wsc_pkg::WSC_MODE_PUSH_PULL: begin
            pins_out = {~st.phase & data_in, st.phase & data_in, ~st.phase & data_in, st.phase & data_in};
         end
         default: begin
            pins_out = 4'h0;
         end
      endcase
   end
endmodule : wsc_mode_drive

/* File: core/wsc_top.sv */
// wsc_top.sv: waveform steering control with apb register slave
// assumes: apb master on core_clk_in, data and shutdown inputs synchronous
//
// Overview of operation
// [RQ1] In modes 000 and 001 the data signal may appear on any mix of the four pins at once.
// [RQ2] A pin whose steer bit is 0 shows its fixed level.
// [RQ3] A pin whose steer bit is 1 follows the data signal.
// [RQ4] Polarity bits change a pin only while its steer bit is 1.
// [RQ5] Shutdown works in steering modes and only alters pins whose steer bit is 1.
// [RQ6] In mode 000 new steer bits reach the pins right after the write.
// [RQ7] In mode 001 new steer bits take effect at the next rising data edge.
// [RQ8] Control bit 7 enables the block when 1 and disables it when 0.
// [RQ9] Control bit 6 requests a buffer load at the next data edge and is then cleared by hardware.
// [RQ10] Software sets the load request only once enable already reads 1.
// [RQ11] Control bits 2..0 choose among steering, sync steering, full-bridge, half-bridge and push-pull.
// [RQ12] All control bits reset to 0 and bits 5..3 read as 0.
// [RQ13] Codes 110 and 111 are reserved and behave as steering.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ns
`include "wsc_cfg.svh"
module wsc_top #(
   parameter int PIN_COUNT = 4
) (
   input  wire logic        core_clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        data_in,
   input  wire logic        shutdown_in,
   output logic [3:0]       wave_output_pins_out
);
   // elaboration check: the pin mapping is built for four pins only
   if (PIN_COUNT != 4) begin : g_bad_pins
      $error("wsc_top supports exactly four output pins");
   end

   typedef struct packed {
      logic        enable;
      logic        load_req;
      logic [2:0]  mode;
      logic [3:0]  steer_sw;        // steer_select_bits as written
      logic [3:0]  steer_act;       // steer bits in force at the pins
      logic [3:0]  polarity_sw;     // output_polarity_bits buffer
      logic [3:0]  polarity_act;
      logic [3:0]  fixed_lvl;
      logic [3:0]  pins;
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
   } wsc_top_state_s;

   wsc_top_state_s st;
   wsc_top_state_s next_st;

   logic       rise;
   logic       fall;
   logic [3:0] bridge_pins;

   // edge pulses of the data input
   wsc_edge_detect u_edge (
      .core_clk_in (core_clk_in),
      .reset_n_in  (reset_n_in),
      .data_in     (data_in),
      .rise_out    (rise),
      .fall_out    (fall)
   );

   // bridge and push-pull levels
   wsc_mode_drive u_drive (
      .core_clk_in (core_clk_in),
      .reset_n_in  (reset_n_in),
      .mode_in     (st.mode),
      .data_in     (data_in),
      .rise_in     (rise),
      .pins_out    (bridge_pins)
   );

   // steering decode shared by the pin logic
   function automatic logic is_steer_mode(input logic [2:0] mode);
      // [RQ13] reserved as steering
      is_steer_mode = (mode[2:1] == 2'b00) || (mode[2:1] == 2'b11);
   endfunction : is_steer_mode

   // one steered pin: fixed level, data with polarity, shutdown
   function automatic logic steer_pin(input logic sel, input logic pol, input logic fix,
                                      input logic dat, input logic sd);
      if (sel) begin
         // [RQ5] shutdown only on steered pins
         steer_pin = sd ? fix : (dat ^ pol);
      end else begin
         steer_pin = fix;
      end
   endfunction : steer_pin

   logic setup_ph;
   logic access;
   logic apb_wr;
   logic apb_rd;
   logic known_addr;

   // apb phases; read data and error are registered at the setup edge so they
   // stand through the access phase, which lets pready stay high with no wait
   assign access     = psel_in & penable_in;
   assign setup_ph   = psel_in & ~penable_in;
   assign apb_wr     = access & pwrite_in;
   assign apb_rd     = setup_ph & ~pwrite_in;
   assign known_addr = (paddr_in == `WSC_OFS_CONTROL) || (paddr_in == `WSC_OFS_STEER) ||
                       (paddr_in == `WSC_OFS_POLARITY) || (paddr_in == `WSC_OFS_FIXED) ||
                       (paddr_in == `WSC_OFS_STATUS);

   // next-state logic: registers, steering, pins and bus answer
   always_comb begin
      logic [3:0] steer_lvl;
      logic       edge_evt;
      steer_lvl = 4'h0;
      edge_evt  = 1'b0;
      next_st   = st;
      edge_evt  = rise | fall;

      // [RQ9] load buffered polarity on next edge then clear
      if (st.load_req && edge_evt) begin
         next_st.polarity_act = st.polarity_sw;
         next_st.load_req     = 1'b0;
      end
      if (!st.enable) begin
         next_st.load_req = 1'b0;
      end

      // [RQ6] asynchronous steering applies at once
      if (st.mode == 3'b000 || st.mode[2:1] == 2'b11) begin
         next_st.steer_act = st.steer_sw;
      // [RQ7] sync steering waits for data rise
      end else if (st.mode == 3'b001 && rise) begin
         next_st.steer_act = st.steer_sw;
      end

      // register writes take effect at the access edge
      if (apb_wr) begin
         unique case (paddr_in)
            `WSC_OFS_CONTROL: begin
               // [RQ8] enable bit
               next_st.enable = pwdata_in[`WSC_CTL_EN_BIT];
               // [RQ11] mode field
               next_st.mode   = pwdata_in[`WSC_CTL_MODE_HI:`WSC_CTL_MODE_LO];
               // [RQ10] load only if already enabled
               if (pwdata_in[`WSC_CTL_LD_BIT] && st.enable) begin
                  next_st.load_req = 1'b1;
               end
            end
            `WSC_OFS_STEER: begin
               next_st.steer_sw = pwdata_in[3:0];
               if (st.mode == 3'b000) begin
                  next_st.steer_act = pwdata_in[3:0];
               end
            end
            `WSC_OFS_POLARITY: begin
               next_st.polarity_sw = pwdata_in[3:0];
               if (!st.enable) begin
                  next_st.polarity_act = pwdata_in[3:0];  // idle block loads directly
               end
            end
            `WSC_OFS_FIXED: begin
               next_st.fixed_lvl = pwdata_in[3:0];
            end
            default: begin
            end
         endcase
      end

      // read data; [RQ12] bits 5..3 read as zero
      next_st.rdata  = 32'h0000_0000;
      next_st.slverr = setup_ph & ~known_addr;
      next_st.ready  = 1'b1;
      if (apb_rd) begin
         unique case (paddr_in)
            `WSC_OFS_CONTROL:  next_st.rdata = {24'h00_0000, st.enable, st.load_req, 3'b000, st.mode};
            `WSC_OFS_STEER:    next_st.rdata = {28'h000_0000, st.steer_sw};
            `WSC_OFS_POLARITY: next_st.rdata = {28'h000_0000, st.polarity_sw};
            `WSC_OFS_FIXED:    next_st.rdata = {28'h000_0000, st.fixed_lvl};
            `WSC_OFS_STATUS:   next_st.rdata = {24'h00_0000, st.pins, st.steer_act};
            default:           next_st.rdata = 32'h0000_0000;
         endcase
      end

      // pin levels
      for (int i = 0; i < 4; i++) begin
         // [RQ1] [RQ2] [RQ3] [RQ4] steered pin level
         steer_lvl[i] = steer_pin(st.steer_act[i], st.polarity_act[i], st.fixed_lvl[i], data_in, shutdown_in);
      end
      if (!st.enable) begin
         next_st.pins = 4'h0;
      end else if (is_steer_mode(st.mode)) begin
         next_st.pins = steer_lvl;
      end else begin
         // shutdown forces the fixed levels in the bridge modes
         next_st.pins = shutdown_in ? st.fixed_lvl : (bridge_pins ^ st.polarity_act);
      end
   end

   // [RQ12] everything clears on reset except ready, which resets to 1
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st       <= '0;
         st.ready <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // outputs from flip-flops; pready from a flop held high
   assign prdata_out           = st.rdata;
   assign pready_out           = st.ready;
   assign pslverr_out          = st.slverr;
   assign wave_output_pins_out = st.pins;
endmodule : wsc_top

/* File: verif/wsc_monitor.sv */
// wsc_monitor.sv: port checks for the steering block
// assumes: bound to wsc_top; shadows follow apb writes
`timescale 1ns/1ns
`include "wsc_cfg.svh"
module wsc_monitor #(
   parameter int PIN_COUNT = 4
) (
   input wire logic        core_clk_in,
   input wire logic        reset_n_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic        data_in,
   input wire logic        shutdown_in,
   input wire logic [3:0]  wave_output_pins_out
);
   typedef struct packed {
      logic       en;
      logic [2:0] mode;
      logic [3:0] steer;
      logic [3:0] fixed;
      logic       pol_used;
      logic [1:0] quiet;
   } wsc_shadow_s;
   wsc_shadow_s sh;
   wsc_shadow_s next_sh;
   logic        acc;
   logic        rd_ctl;
   assign acc = psel_in && penable_in && pready_out;
   assign rd_ctl = acc && !pwrite_in && paddr_in == `WSC_OFS_CONTROL;
   // quiet counts idle cycles up to 3, so pins are checked only once they have settled after a write
   always_comb begin
      next_sh = sh;
      if (sh.quiet != 2'h3) next_sh.quiet = sh.quiet + 2'h1;
      if (acc && pwrite_in) begin
         next_sh.quiet = 2'h0;
         if (paddr_in == `WSC_OFS_CONTROL) {next_sh.en, next_sh.mode} = {pwdata_in[7], pwdata_in[2:0]};
         if (paddr_in == `WSC_OFS_STEER) next_sh.steer = pwdata_in[3:0];
         if (paddr_in == `WSC_OFS_POLARITY) next_sh.pol_used = 1'b1;
         if (paddr_in == `WSC_OFS_FIXED) next_sh.fixed = pwdata_in[3:0];
      end
   end
   // shadow register
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) sh <= '0;
      else sh <= next_sh;
   end
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_calm;
      sh.quiet == 2'h3 && $past(data_in) == $past(data_in, 2) && $past(shutdown_in) == $past(shutdown_in, 2);
   endsequence
   property p_off;
      sh.quiet == 2'h3 && !sh.en |-> wave_output_pins_out == 4'h0;
   endproperty
   property p_fixed;
      s_calm ##0 (sh.en && sh.mode == 3'h0) |-> ((wave_output_pins_out ^ sh.fixed) & ~sh.steer) == 4'h0;
   endproperty
   property p_follow;
      s_calm ##0 (sh.en && sh.mode == 3'h0 && !sh.pol_used && !$past(shutdown_in))
         |-> ((wave_output_pins_out ^ {4{$past(data_in)}}) & sh.steer) == 4'h0;
   endproperty
   property p_trip;
      s_calm ##0 (sh.en && sh.mode == 3'h0 && $past(shutdown_in)) |-> wave_output_pins_out == sh.fixed;
   endproperty
   property p_now;
      acc && pwrite_in && paddr_in == `WSC_OFS_STEER && sh.en && sh.mode == 3'h0 && !sh.pol_used && !shutdown_in
         |-> ##3 ((wave_output_pins_out ^ {4{data_in}}) & sh.steer) == 4'h0;
   endproperty
   property p_bits;
      rd_ctl |-> prdata_out[31:8] == 24'h0 && prdata_out[5:3] == 3'h0;
   endproperty
   property p_ctl;
      rd_ctl |-> prdata_out[7] == sh.en && prdata_out[2:0] == sh.mode;
   endproperty
   property p_ld;
      rd_ctl && !sh.en |-> !prdata_out[6];
   endproperty
   a_off: assert property (p_off) else $error("pins active while disabled");
   a_fixed: assert property (p_fixed) else $error("unsteered pin off its fixed level");
   a_follow: assert property (p_follow) else $error("steered pin not following data");
   a_trip: assert property (p_trip) else $error("shutdown level wrong");
   a_now: assert property (p_now) else $error("steer change late");
   a_bits: assert property (p_bits) else $error("unused control bits set");
   a_ctl: assert property (p_ctl) else $error("control readback wrong");
   a_ld: assert property (p_ld) else $error("load request kept while disabled");
   c_trip: cover property (sh.en && shutdown_in && sh.steer != 4'h0);
   c_sync: cover property (sh.en && sh.mode == 3'h1 && $rose(data_in));
   c_ld: cover property (acc && pwrite_in && paddr_in == `WSC_OFS_CONTROL && pwdata_in[6]);
endmodule : wsc_monitor
bind wsc_top wsc_monitor #(.PIN_COUNT(PIN_COUNT)) u_wsc_monitor (.core_clk_in(core_clk_in),
   .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
   .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .data_in(data_in), .shutdown_in(shutdown_in),
   .wave_output_pins_out(wave_output_pins_out));

/* File: verif/wsc_switch_model.sv */
// wsc_switch_model.sv: gate drivers of the external power switches
// assumes: one driver stage per output pin, same clock
`timescale 1ns/1ns
module wsc_switch_model (
   input  wire logic       core_clk_in,
   input  wire logic       reset_n_in,
   input  wire logic [3:0] gate_in,
   output logic      [3:0] switch_on_out
);
   // driver stage adds one clock of delay
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) switch_on_out <= 4'h0;
      else switch_on_out <= gate_in;
   end
endmodule : wsc_switch_model

/* File: verif/wsc_top_tb_top.sv */
// wsc_top_tb_top.sv: directed bench for the steering block
// assumes: apb slave answers at once, pins settle in a few clocks
`timescale 1ns/1ns
`include "wsc_cfg.svh"
module wsc_top_tb_top;
   typedef struct {logic [7:0] ctl; logic [3:0] steer, fixed; logic dat, sd; logic [3:0] pins;} wsc_row_s;
   logic        core_clk_in = 1'b0;
   logic        reset_n_in = 1'b0;
   logic        psel_in = 1'b0;
   logic        penable_in = 1'b0;
   logic        pwrite_in = 1'b0;
   logic        data_in = 1'b0;
   logic        shutdown_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0;
   logic [31:0] prdata_out;
   logic [31:0] rd;
   logic        pready_out;
   logic        pslverr_out;
   logic        err;
   logic [3:0]  wave_output_pins_out;
   logic [3:0]  switch_on;
   int          num_errors = 0;
   int          checks = 0;
   wsc_row_s    rows [6] = '{
      '{8'h80, 4'hF, 4'h0, 1'b1, 1'b0, 4'hF},
      '{8'h80, 4'h5, 4'h2, 1'b1, 1'b0, 4'h7},
      '{8'h80, 4'h5, 4'h2, 1'b0, 1'b0, 4'h2},
      '{8'h80, 4'h5, 4'h2, 1'b1, 1'b1, 4'h2},
      '{8'h80, 4'h9, 4'h6, 1'b0, 1'b1, 4'h6},
      '{8'h00, 4'hF, 4'h0, 1'b1, 1'b0, 4'h0}};
   wsc_top #(.PIN_COUNT(4)) u_wsc_top (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .data_in(data_in),
      .shutdown_in(shutdown_in), .wave_output_pins_out(wave_output_pins_out));
   wsc_switch_model u_wsc_switch_model (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .gate_in(wave_output_pins_out), .switch_on_out(switch_on));
   task automatic print_verdict();
      if (num_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   task automatic cmp_w(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_w
   // pins seen through the switch model once settled; a data edge that moves the
   // active steer or polarity copy reaches the pins as fast as a register write
   task automatic cmp_p(input string nm, input logic [3:0] e);
      repeat (4) @(posedge core_clk_in);
      cmp_w(nm, {28'h0, e}, {28'h0, switch_on});
   endtask : cmp_p
   // one apb transfer; read data and error taken at the edge that sees pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge core_clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 16);
      if (pready_out !== 1'b1) begin
         num_errors++;
         print_verdict();
      end
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb
   // free running clock
   initial begin
      forever #50 core_clk_in = ~core_clk_in;
   end
   // main sequence
   initial begin
      repeat (3) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      apb(0, `WSC_OFS_CONTROL, 0);
      cmp_w("control reset", 32'h0, rd);
      foreach (rows[i]) begin
         data_in <= rows[i].dat;
         shutdown_in <= rows[i].sd;
         apb(1, `WSC_OFS_CONTROL, {24'h0, rows[i].ctl});
         apb(1, `WSC_OFS_STEER, {28'h0, rows[i].steer});
         apb(1, `WSC_OFS_FIXED, {28'h0, rows[i].fixed});
         cmp_p("row pins", rows[i].pins);
      end
      for (int m = 0; m < 6; m++) begin
         apb(1, `WSC_OFS_CONTROL, 32'h80 | 32'(m));
         apb(0, `WSC_OFS_CONTROL, 0);
         cmp_w("mode", 32'h80 | 32'(m), rd);
      end
      // load request cleared when a write disables, refused when set together with enable
      apb(1, `WSC_OFS_CONTROL, 32'h7F);
      apb(0, `WSC_OFS_CONTROL, 0);
      cmp_w("control masked", 32'h07, rd);
      apb(1, `WSC_OFS_CONTROL, 32'hC0);
      apb(0, `WSC_OFS_CONTROL, 0);
      cmp_w("load with enable", 32'h80, rd);
      // sync steering waits for a rising data edge
      apb(1, `WSC_OFS_STEER, 0);
      apb(1, `WSC_OFS_CONTROL, 32'h81);
      apb(1, `WSC_OFS_STEER, 32'hF);
      cmp_p("sync hold", 4'h0);
      apb(0, `WSC_OFS_STATUS, 0);
      cmp_w("status hold", 32'h00, rd);
      data_in <= 1'b0;
      @(posedge core_clk_in);
      data_in <= 1'b1;
      cmp_p("sync taken", 4'hF);
      apb(1, `WSC_OFS_CONTROL, 32'h80);
      apb(1, `WSC_OFS_STEER, 0);
      cmp_p("async off", 4'h0);
      // polarity held in its buffer until a load
      apb(1, `WSC_OFS_STEER, 32'hF);
      apb(1, `WSC_OFS_POLARITY, 32'hF);
      cmp_p("pol buffered", 4'hF);
      apb(1, `WSC_OFS_CONTROL, 32'hC0);
      apb(0, `WSC_OFS_CONTROL, 0);
      cmp_w("load pending", 32'hC0, rd);
      data_in <= 1'b0;
      cmp_p("pol loaded", 4'hF);
      apb(0, `WSC_OFS_CONTROL, 0);
      cmp_w("load cleared", 32'h80, rd);
      apb(1, `WSC_OFS_STEER, 0);
      cmp_p("pol ignored", 4'h0);
      apb(0, 12'h020, 0);
      cmp_w("unmapped error", 32'h1, {31'h0, err});
      reset_n_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      apb(0, `WSC_OFS_CONTROL, 0);
      cmp_w("control rereset", 32'h0, rd);
      cmp_p("pins rereset", 4'h0);
      print_verdict();
   end
endmodule : wsc_top_tb_top
